// ### common/nvc_regs.svh
// Register offsets, field positions, command codes and reset values
// of the nonvolatile command control block.
// Assumes byte-wide registers on a plain strobe port, one clock.
//
// Overview of operation
// (R1) Full-chip and EEPROM-only erase codes start their erase on the write itself.
// (R2) Other valid codes only arm a mode; a CPU store starts the array operation.
// (R3) Software passes through no-command or no-operation between two commands.
// (R4) Code 0x02 arms flash write; code 0x08 arms single flash page erase.
// (R5) Codes 0x09 to 0x0D arm flash erase of 2, 4, 8, 16, 32 pages.
// (R6) Code 0x12 arms EEPROM write; 0x13 arms EEPROM erase then write.
// (R7) Code 0x18 arms EEPROM byte erase; 0x19 to 0x1D erase 2 to 32 bytes.
// (R8) Full-chip erase only from programming port; preserve fuse keeps EEPROM intact.
// (R9) Reserved or unsupported command code sets error code to invalid command.
// (R10) Store into a protected section is blocked and sets write-protect error.
// (R11) New write or erase command during an ongoing one sets collision error.
// (R12) Error field in status 6:4 holds last error; writing zero clears it.
// (R13) Status bit 1 reads one while EEPROM programming is in progress.
// (R14) Status bit 0 reads one while flash programming is in progress.
// (R15) Mapping lock freezes the flash window field; only reset clears the lock.
// (R16) Window field in bits 5:4 selects block; every setting maps block zero.
// (R17) Window field writes need no unlock; other protection bits need it.
// (R18) Application data protect bit blocks data section writes until reset.
// (R19) Application code protect bit blocks code section writes until reset.
// (R20) Active boot protection: foreign reads of boot give zero, fetches a no-op.
// (R21) Boot protect bit written only from boot, reset clears, acts after leaving.
// (R22) Command and protection registers change only inside the unlock window; the window field 5:4 changes without it.
// (R23) EEPROM ready flag stays set while EEPROM idle; writing one clears it.
// (R24) Interrupt asserted while ready flag and enable both set, until flag cleared.
// (R25) Unused and reserved bits read zero and ignore writes.
`ifndef NVC_REGS_SVH
`define NVC_REGS_SVH
`define NVC_OFS_CMD 4'h0
`define NVC_OFS_PMAP 4'h1
`define NVC_OFS_STAT 4'h2
`define NVC_OFS_IEN 4'h3
`define NVC_OFS_IFLG 4'h4
`define NVC_OFS_DATA0 4'h6
`define NVC_OFS_DATA1 4'h7
`define NVC_OFS_ADDR0 4'h8
`define NVC_OFS_ADDR1 4'h9
`define NVC_OFS_ADDR2 4'hA
`define NVC_CMD_NONE 7'h00
`define NVC_CMD_NOP 7'h01
`define NVC_CMD_FLASH_WRITE_ARM 7'h02
`define NVC_CMD_FLPE 7'h08
`define NVC_CMD_FLMP32 7'h0D
`define NVC_CMD_EEPROM_WRITE_ARM 7'h12
`define NVC_CMD_EEEW 7'h13
`define NVC_CMD_EEBE 7'h18
`define NVC_CMD_EEMB32 7'h1D
`define NVC_CMD_CHIP 7'h20
`define NVC_CMD_EEALL 7'h30
`define NVC_ERR_NONE 3'h0
`define NVC_ERR_BADCMD 3'h1
`define NVC_ERR_PROT 3'h2
`define NVC_ERR_COLL 3'h3
`define NVC_CMD_F 6:0
`define NVC_PM_LOCK 7
`define NVC_PM_MAP 5:4
`define NVC_PM_ADWP 2
`define NVC_PM_BRP 1
`define NVC_PM_ACWP 0
`define NVC_ST_ERR 6:4
`define NVC_ST_EEB 1
`define NVC_ST_FB 0
`define NVC_IRQ_BIT 0
`define NVC_B0 7:0
`define NVC_B1 15:8
`define NVC_B2 23:16
`define NVC_MAP_RST 2'h3
`define NVC_MAP_BLOCK0 2'h0
`define NVC_SEC_BOOT 2'h0
`define NVC_SEC_CODE 2'h1
`define NVC_SEC_DATA 2'h2
`define NVC_SEC_EE 2'h3
`endif

// ### common/nvc_pkg.sv
// Types of the nonvolatile command control block.
// Assumes nvc_regs.svh supplies the numeric constants.
package nvc_pkg;
  // Whole state of the block, registered in one place
  typedef struct packed {
    logic [6:0] cmd;
    logic lock;
    logic [1:0] map;
    logic ad_wp;
    logic b_rp;
    logic b_rp_act;
    logic ac_wp;
    logic [2:0] err;
    logic ee_busy;
    logic fl_busy;
    logic ie;
    logic ee_rdy;
    logic [15:0] data;
    logic [23:0] addr;
    logic [7:0] rdata;
    logic op_start;
    logic [6:0] op_cmd;
    logic [23:0] op_addr;
    logic [15:0] op_data;
    logic op_skip;
    logic [15:0] cpu_rdata;
    logic cpu_rvalid;
    logic st_rdy;
    logic [1:0] mblk;
    logic irq;
  } nvc_state_t;
endpackage

// ### rtl/nvc_top.sv
// Command, protection and status front end of the flash/EEPROM controller.
// Assumes the CPU, unlock logic and arrays all run on clk; no input is
// synchronised here. Arrays report completion with one-cycle done pulses.
`timescale 1ns/100ps
`include "nvc_regs.svh"

module nvc_top
  import nvc_pkg::*;
#(
  parameter logic [15:0] NOP_WORD = 16'h0000
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic ccp_unlock,
  input wire logic from_prog_port,
  input wire logic pc_in_boot,
  input wire logic eeprom_preserve_fuse,
  input wire logic store_valid,
  input wire logic [1:0] store_section,
  input wire logic [23:0] store_addr,
  input wire logic [15:0] store_data,
  input wire logic flash_done,
  input wire logic eeprom_done,
  input wire logic mem_rd_valid,
  input wire logic mem_rd_fetch,
  input wire logic mem_rd_boot,
  input wire logic [15:0] mem_rd_data,
  output logic [15:0] cpu_rd_data,
  output logic cpu_rd_valid,
  output logic op_start,
  output logic [6:0] op_cmd,
  output logic [23:0] op_addr,
  output logic [15:0] op_data,
  output logic op_skip_eeprom,
  output logic store_ready,
  output logic [1:0] flash_window,
  output logic [1:0] mapped_block,
  output logic irq
);

  nvc_state_t st_r;
  nvc_state_t st_nxt;

  // No-command or no-operation: nothing armed
  function automatic logic is_idle_code(input logic [6:0] c);
    is_idle_code = (c == `NVC_CMD_NONE) || (c == `NVC_CMD_NOP);
  endfunction

  // Flash write and page erase arming codes
  function automatic logic is_fl_arm(input logic [6:0] c);
    is_fl_arm = (c == `NVC_CMD_FLASH_WRITE_ARM) ||
                ((c >= `NVC_CMD_FLPE) && (c <= `NVC_CMD_FLMP32));
  endfunction

  // EEPROM write, erase-write and byte erase arming codes
  function automatic logic is_ee_arm(input logic [6:0] c);
    is_ee_arm = (c == `NVC_CMD_EEPROM_WRITE_ARM) || (c == `NVC_CMD_EEEW) ||
                ((c >= `NVC_CMD_EEBE) && (c <= `NVC_CMD_EEMB32));
  endfunction

  // Every code that the command field accepts
  function automatic logic is_valid(input logic [6:0] c);
    is_valid = is_idle_code(c) || is_fl_arm(c) || is_ee_arm(c) ||
               (c == `NVC_CMD_CHIP) || (c == `NVC_CMD_EEALL);
  endfunction

  // Next state of the whole block
  always_comb begin
    logic hw_err;
    logic [2:0] hw_code;
    logic [6:0] code;
    logic sec_prot;
    logic sec_ee;
    logic start_fl;
    logic start_ee;
    hw_err = 1'b0;
    hw_code = `NVC_ERR_NONE;
    code = reg_wdata[`NVC_CMD_F];
    sec_prot = 1'b0;
    sec_ee = 1'b0;
    start_fl = 1'b0;
    start_ee = 1'b0;
    st_nxt = st_r;

    // Pulses and read data last one cycle only
    st_nxt.op_start = 1'b0;
    st_nxt.rdata = 8'h00;
    st_nxt.cpu_rvalid = 1'b0;

    // Command field, only inside the unlock window
    if (reg_wr && (reg_addr == `NVC_OFS_CMD) && ccp_unlock) begin // (R22)
      if (is_idle_code(code)) begin
        st_nxt.cmd = code;
      end else if (!is_valid(code)) begin
        hw_err = 1'b1; // (R9)
        hw_code = `NVC_ERR_BADCMD;
      end else if ((code == `NVC_CMD_CHIP) && !from_prog_port) begin
        // CPU may not issue chip erase; report as unsupported
        hw_err = 1'b1; // (R8)
        hw_code = `NVC_ERR_BADCMD;
      end else if ((!is_idle_code(st_r.cmd) && (code != st_r.cmd)) ||
                   st_r.fl_busy || st_r.ee_busy) begin
        // Command left unchanged so the ongoing one keeps its mode
        hw_err = 1'b1; // (R11)
        hw_code = `NVC_ERR_COLL;
      end else begin
        st_nxt.cmd = code; // (R4) (R5) (R6) (R7)
        if (code == `NVC_CMD_CHIP) begin
          // Protection bits do not stop a chip erase
          start_fl = 1'b1; // (R1)
          start_ee = !eeprom_preserve_fuse; // (R8)
          st_nxt.op_start = 1'b1;
          st_nxt.op_cmd = code;
          st_nxt.op_skip = eeprom_preserve_fuse; // (R8)
        end else if (code == `NVC_CMD_EEALL) begin
          start_ee = 1'b1; // (R1)
          st_nxt.op_start = 1'b1;
          st_nxt.op_cmd = code;
          st_nxt.op_skip = 1'b0;
        end
      end
    end

    // Protection and window register
    if (reg_wr && (reg_addr == `NVC_OFS_PMAP)) begin
      if (!st_r.lock) begin
        st_nxt.map = reg_wdata[`NVC_PM_MAP]; // (R15) (R17)
      end
      if (ccp_unlock) begin // (R22)
        // Set-only bits: software never clears them
        st_nxt.lock = st_r.lock | reg_wdata[`NVC_PM_LOCK]; // (R15)
        st_nxt.ad_wp = st_r.ad_wp | reg_wdata[`NVC_PM_ADWP]; // (R18)
        st_nxt.ac_wp = st_r.ac_wp | reg_wdata[`NVC_PM_ACWP]; // (R19)
        if (pc_in_boot) begin
          st_nxt.b_rp = st_r.b_rp | reg_wdata[`NVC_PM_BRP]; // (R21)
        end
      end
    end

    // Boot protection arms once execution has left boot
    if (st_r.b_rp && !pc_in_boot) begin
      st_nxt.b_rp_act = 1'b1; // (R21)
    end

    // Error field: software may write it, zero clears it
    if (reg_wr && (reg_addr == `NVC_OFS_STAT)) begin
      st_nxt.err = reg_wdata[`NVC_ST_ERR]; // (R12)
    end

    // Interrupt enable
    if (reg_wr && (reg_addr == `NVC_OFS_IEN)) begin
      st_nxt.ie = reg_wdata[`NVC_IRQ_BIT];
    end

    // Data and address registers are software writable too
    if (reg_wr) begin
      unique case (reg_addr)
        `NVC_OFS_DATA0: st_nxt.data[`NVC_B0] = reg_wdata;
        `NVC_OFS_DATA1: st_nxt.data[`NVC_B1] = reg_wdata;
        `NVC_OFS_ADDR0: st_nxt.addr[`NVC_B0] = reg_wdata;
        `NVC_OFS_ADDR1: st_nxt.addr[`NVC_B1] = reg_wdata;
        `NVC_OFS_ADDR2: st_nxt.addr[`NVC_B2] = reg_wdata;
        default: ;
      endcase
    end

    // CPU store carries out the armed mode
    if (store_valid) begin
      st_nxt.addr = store_addr;
      sec_ee = (store_section == `NVC_SEC_EE);
      sec_prot = ((store_section == `NVC_SEC_CODE) && st_r.ac_wp) || // (R19)
                 ((store_section == `NVC_SEC_DATA) && st_r.ad_wp); // (R18)
      if ((is_fl_arm(st_r.cmd) && !sec_ee) ||
          (is_ee_arm(st_r.cmd) && sec_ee)) begin
        if (sec_prot) begin
          hw_err = 1'b1; // (R10)
          hw_code = `NVC_ERR_PROT;
        end else if (!st_r.fl_busy && !st_r.ee_busy) begin
          // Busy array: store is dropped, store_ready warns ahead
          start_fl = !sec_ee; // (R2)
          start_ee = sec_ee;
          st_nxt.op_start = 1'b1;
          st_nxt.op_cmd = st_r.cmd;
          st_nxt.op_addr = store_addr;
          st_nxt.op_data = store_data;
          st_nxt.op_skip = 1'b0;
        end
      end
    end

    // Hardware error wins over a software write in the same cycle
    if (hw_err) begin
      st_nxt.err = hw_code; // (R12)
    end

    // Busy flags: a start wins over a done
    if (start_fl) begin
      st_nxt.fl_busy = 1'b1; // (R14)
    end else if (flash_done) begin
      st_nxt.fl_busy = 1'b0; // (R14)
    end
    if (start_ee) begin
      st_nxt.ee_busy = 1'b1; // (R13)
    end else if (eeprom_done) begin
      st_nxt.ee_busy = 1'b0; // (R13)
    end
    st_nxt.st_rdy = !st_nxt.fl_busy && !st_nxt.ee_busy;

    // Ready flag is forced high whenever EEPROM is idle
    if (!st_nxt.ee_busy) begin
      st_nxt.ee_rdy = 1'b1; // (R23)
    end else if (reg_wr && (reg_addr == `NVC_OFS_IFLG) &&
                 reg_wdata[`NVC_IRQ_BIT]) begin
      st_nxt.ee_rdy = 1'b0; // (R23)
    end
    // Level request follows the registered flag and enable
    st_nxt.irq = st_nxt.ee_rdy & st_nxt.ie; // (R24)

    // Window field has no effect on which block is mapped
    st_nxt.mblk = `NVC_MAP_BLOCK0; // (R16)

    // Array reads, filtered by boot read protection
    if (mem_rd_valid) begin
      st_nxt.cpu_rvalid = 1'b1;
      if (st_r.b_rp_act && mem_rd_boot && mem_rd_fetch) begin
        st_nxt.cpu_rdata = NOP_WORD; // (R20)
      end else if (st_r.b_rp_act && mem_rd_boot && !pc_in_boot) begin
        st_nxt.cpu_rdata = 16'h0000; // (R20)
      end else begin
        st_nxt.cpu_rdata = mem_rd_data;
      end
      st_nxt.data = st_nxt.cpu_rdata;
    end

    // Register read; unused bits and offsets give zero
    if (reg_rd) begin
      unique case (reg_addr)
        `NVC_OFS_CMD: st_nxt.rdata[`NVC_CMD_F] = st_r.cmd; // (R25)
        `NVC_OFS_PMAP: begin
          st_nxt.rdata[`NVC_PM_LOCK] = st_r.lock;
          st_nxt.rdata[`NVC_PM_MAP] = st_r.map;
          st_nxt.rdata[`NVC_PM_ADWP] = st_r.ad_wp;
          st_nxt.rdata[`NVC_PM_BRP] = st_r.b_rp;
          st_nxt.rdata[`NVC_PM_ACWP] = st_r.ac_wp;
        end
        `NVC_OFS_STAT: begin
          st_nxt.rdata[`NVC_ST_ERR] = st_r.err; // (R12)
          st_nxt.rdata[`NVC_ST_EEB] = st_r.ee_busy; // (R13)
          st_nxt.rdata[`NVC_ST_FB] = st_r.fl_busy; // (R14)
        end
        `NVC_OFS_IEN: st_nxt.rdata[`NVC_IRQ_BIT] = st_r.ie;
        `NVC_OFS_IFLG: st_nxt.rdata[`NVC_IRQ_BIT] = st_r.ee_rdy;
        `NVC_OFS_DATA0: st_nxt.rdata = st_r.data[`NVC_B0];
        `NVC_OFS_DATA1: st_nxt.rdata = st_r.data[`NVC_B1];
        `NVC_OFS_ADDR0: st_nxt.rdata = st_r.addr[`NVC_B0];
        `NVC_OFS_ADDR1: st_nxt.rdata = st_r.addr[`NVC_B1];
        `NVC_OFS_ADDR2: st_nxt.rdata = st_r.addr[`NVC_B2];
        default: st_nxt.rdata = 8'h00; // (R25)
      endcase
    end
  end

  // Single register stage; clock enable freezes everything but reset
  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= '0;
      st_r.map <= `NVC_MAP_RST;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata = st_r.rdata;
  assign cpu_rd_data = st_r.cpu_rdata;
  assign cpu_rd_valid = st_r.cpu_rvalid;
  assign op_start = st_r.op_start;
  assign op_cmd = st_r.op_cmd;
  assign op_addr = st_r.op_addr;
  assign op_data = st_r.op_data;
  assign op_skip_eeprom = st_r.op_skip;
  assign store_ready = st_r.st_rdy;
  assign flash_window = st_r.map;
  assign mapped_block = st_r.mblk;
  assign irq = st_r.irq;

endmodule

// ### bench/nvc_monitor.sv
// Port checker for nvc_top, bound to every instance.
// Assumes one clock and a synchronous active high reset.
`timescale 1ns/100ps
module nvc_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic store_valid,
  input wire logic flash_done,
  input wire logic eeprom_done,
  input wire logic op_start,
  input wire logic [6:0] op_cmd,
  input wire logic store_ready,
  input wire logic [1:0] flash_window,
  input wire logic [1:0] mapped_block,
  input wire logic irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // Only one 32 KB block exists, so every window setting maps block zero
  chk_window_zero: assert property (mapped_block == 2'h0)
    else $error("mapped block not zero");
  // Full-chip and EEPROM-only erase codes start on the register write itself
  chk_erase_now: assert property (op_start && op_cmd[5] |->
    $past(reg_wr && reg_addr == 4'h0) && $past(reg_wdata[6:0]) == op_cmd)
    else $error("erase start without command write");
  chk_store_start: assert property (op_start && !op_cmd[5] |-> $past(store_valid))
    else $error("armed operation without store");
  chk_busy_start: assert property (op_start |-> !store_ready)
    else $error("ready high at start");
  // Ready rises one edge after reset release with no done pulse
  chk_ready_done: assert property ($rose(store_ready) && !$past(reset, 2) |->
    $past(flash_done || eeprom_done)) else $error("ready without done");
  // A frozen clock enable loses the strobe, so it qualifies the write
  chk_irq_on: assert property (clk_en && reg_wr && reg_addr == 4'h3 && reg_wdata[0]
    && store_ready && !store_valid |-> ##[1:2] irq) else $error("irq missing");
  chk_irq_off: assert property (clk_en && reg_wr && reg_addr == 4'h3 && !reg_wdata[0]
    |=> ##1 !irq) else $error("irq stuck");
  chk_window_write: assert property ($changed(flash_window) |->
    $past(reg_wr && reg_addr == 4'h1)) else $error("window changed alone");
endmodule

bind nvc_top nvc_monitor u_mon (
  .clk(clk), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .store_valid(store_valid), .flash_done(flash_done), .eeprom_done(eeprom_done),
  .op_start(op_start), .op_cmd(op_cmd), .store_ready(store_ready),
  .flash_window(flash_window), .mapped_block(mapped_block), .irq(irq)
);

// ### bench/nvc_mem_model.sv
// Behavioural flash and EEPROM arrays behind nvc_top.
// Assumes op_start pulses on clk; done pulses come back after a delay.
`timescale 1ns/100ps
module nvc_mem_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic slow,
  input wire logic op_start,
  input wire logic [6:0] op_cmd,
  input wire logic op_skip_eeprom,
  output logic flash_done,
  output logic eeprom_done
);
  logic [5:0] f_cnt_r, e_cnt_r, n;
  logic is_fl, is_ee;
  // Flash takes arm codes below 0x10 and chip erase
  assign is_fl = op_cmd < 7'h10 || op_cmd == 7'h20;
  assign is_ee = (op_cmd == 7'h20) ? !op_skip_eeprom : !is_fl;
  assign n = slow ? 6'h14 : 6'h03;
  // Countdowns; slow mode keeps the busy flags up long enough to poll
  always_ff @(posedge clk) begin
    if (reset) begin
      f_cnt_r <= 6'h00;
      e_cnt_r <= 6'h00;
      flash_done <= 1'b0;
      eeprom_done <= 1'b0;
    end else begin
      f_cnt_r <= (op_start && is_fl) ? n : f_cnt_r - {5'h00, f_cnt_r != 6'h00};
      e_cnt_r <= (op_start && is_ee) ? n : e_cnt_r - {5'h00, e_cnt_r != 6'h00};
      flash_done <= f_cnt_r == 6'h01;
      eeprom_done <= e_cnt_r == 6'h01;
    end
  end
endmodule

// ### bench/tb_nvc_top.sv
// Self-checking bench for nvc_top with the array model.
// Assumes one 125 MHz clock and the strobe register port.
`timescale 1ns/100ps
module tb_nvc_top;
  typedef struct packed {logic u; logic [3:0] a; logic [7:0] d; logic [3:0] ra; logic [7:0] e;}
    nvc_row_t;
  logic clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, ccp_unlock = 1'b1, fuse = 1'b1;
  logic from_prog_port = 1'b0, pc_in_boot = 1'b0, store_valid = 1'b0, slow = 1'b1;
  logic mem_rd_valid = 1'b0, mem_rd_boot = 1'b0, flash_done, eeprom_done, cpu_rd_valid;
  logic op_start, op_skip_eeprom, store_ready, irq;
  logic clk_en = 1'b1, mem_rd_fetch = 1'b0;
  // Arbitrary no-op word, apart from zero so fetches and data reads differ
  localparam logic [15:0] NOP_W = 16'hC3C3;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic [1:0] store_section = 2'h0, flash_window, mapped_block;
  logic [23:0] store_addr = 24'h000000, op_addr;
  logic [15:0] store_data = 16'h0000, mem_rd_data = 16'h1234, cpu_rd_data, op_data;
  logic [6:0] op_cmd;
  int n_errors = 0, checks = 0, i, k;
  logic [6:0] codes [15] = '{7'h02, 7'h08, 7'h09, 7'h0A, 7'h0B, 7'h0C, 7'h0D, 7'h12, 7'h13,
    7'h18, 7'h19, 7'h1A, 7'h1B, 7'h1C, 7'h1D};
  logic [11:0] rst_tab [7] = '{12'h000, 12'h130, 12'h200, 12'h300, 12'h401, 12'h600, 12'h800};
  // Unlock, offset, data, read-back offset, expected byte
  nvc_row_t rows [17] = '{'{1'b0, 4'h0, 8'h02, 4'h0, 8'h00}, '{1'b0, 4'h1, 8'h27, 4'h1, 8'h20},
    '{1'b1, 4'h0, 8'h03, 4'h2, 8'h10}, '{1'b1, 4'h2, 8'h00, 4'h2, 8'h00},
    '{1'b1, 4'h0, 8'h7F, 4'h2, 8'h10}, '{1'b1, 4'h2, 8'h00, 4'h2, 8'h00},
    '{1'b1, 4'h0, 8'h20, 4'h2, 8'h10}, '{1'b1, 4'h2, 8'h70, 4'h2, 8'h70},
    '{1'b1, 4'h2, 8'h8F, 4'h2, 8'h00}, '{1'b1, 4'h3, 8'hFF, 4'h3, 8'h01},
    '{1'b1, 4'h3, 8'h00, 4'h3, 8'h00}, '{1'b1, 4'h6, 8'hA5, 4'h6, 8'hA5},
    '{1'b1, 4'h7, 8'h5A, 4'h7, 8'h5A}, '{1'b1, 4'hA, 8'h33, 4'hA, 8'h33},
    '{1'b1, 4'h5, 8'hFF, 4'h5, 8'h00}, '{1'b1, 4'h1, 8'h85, 4'h1, 8'h85},
    '{1'b1, 4'h1, 8'h30, 4'h1, 8'h85}};

  nvc_top #(.NOP_WORD(NOP_W)) dut (
    .clk(clk), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ccp_unlock(ccp_unlock),
    .from_prog_port(from_prog_port), .pc_in_boot(pc_in_boot), .eeprom_preserve_fuse(fuse),
    .store_valid(store_valid), .store_section(store_section), .store_addr(store_addr),
    .store_data(store_data), .flash_done(flash_done), .eeprom_done(eeprom_done),
    .mem_rd_valid(mem_rd_valid), .mem_rd_fetch(mem_rd_fetch), .mem_rd_boot(mem_rd_boot),
    .mem_rd_data(mem_rd_data), .cpu_rd_data(cpu_rd_data), .cpu_rd_valid(cpu_rd_valid),
    .op_start(op_start), .op_cmd(op_cmd), .op_addr(op_addr), .op_data(op_data),
    .op_skip_eeprom(op_skip_eeprom), .store_ready(store_ready), .flash_window(flash_window),
    .mapped_block(mapped_block), .irq(irq));
  nvc_mem_model u_mem (.clk(clk), .reset(reset), .slow(slow), .op_start(op_start),
    .op_cmd(op_cmd), .op_skip_eeprom(op_skip_eeprom), .flash_done(flash_done),
    .eeprom_done(eeprom_done));

  initial forever #4 clk = ~clk;
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Strobes last one cycle; signals move only just after an edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask
  task automatic st(input logic [1:0] s, input logic [23:0] a);
    @(posedge clk);
    store_valid <= 1'b1;
    store_section <= s;
    store_addr <= a;
    store_data <= a[15:0];
    @(posedge clk);
    store_valid <= 1'b0;
    #1;
  endtask
  task automatic mrd(input logic b, input logic f, input logic [15:0] e);
    @(posedge clk);
    mem_rd_valid <= 1'b1;
    mem_rd_boot <= b;
    mem_rd_fetch <= f;
    @(posedge clk);
    mem_rd_valid <= 1'b0;
    #1;
    chk({cpu_rd_valid, cpu_rd_data}, {1'b1, e});
  endtask
  task automatic wait_rdy;
    for (k = 0; k < 200 && store_ready !== 1'b1; k++) @(posedge clk);
    #1;
    chk(store_ready, 1'b1);
  endtask
  task automatic stop_test;
    $display("Counts: %0d checks, %0d mismatches", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Whole run is a few hundred cycles; far beyond that is a hang
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    stop_test;
  end

  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    for (i = 0; i < 17; i++) begin
      @(posedge clk) ccp_unlock <= rows[i].u;
      wr(rows[i].a, rows[i].d);
      rd(rows[i].ra, rows[i].e);
    end
    $display("register table done");
    wr(4'h0, 8'h00);
    foreach (codes[j]) begin
      wr(4'h0, {1'b0, codes[j]});
      rd(4'h0, {1'b0, codes[j]});
      wr(4'h0, 8'h00);
    end
    rd(4'h2, 8'h00);
    $display("command codes done");
    // Code and data sections were protected by the table
    wr(4'h0, 8'h02);
    st(2'h1, 24'h001234);
    chk(op_start, 1'b0);
    rd(4'h2, 8'h20);
    wr(4'h2, 8'h00);
    st(2'h2, 24'h002345);
    rd(4'h2, 8'h20);
    wr(4'h2, 8'h00);
    st(2'h0, 24'h03ABCD);
    chk({op_start, op_cmd, op_addr, op_data}, {1'b1, 7'h02, 24'h03ABCD, 16'hABCD});
    wr(4'h0, 8'h08);
    rd(4'h2, 8'h31);
    wait_rdy;
    rd(4'h2, 8'h30);
    wr(4'h2, 8'h00);
    wr(4'h0, 8'h00);
    $display("store test done");
    wr(4'h3, 8'h01);
    rd(4'h4, 8'h01);
    chk(irq, 1'b1);
    wr(4'h0, 8'h30);
    chk({op_start, op_cmd}, {1'b1, 7'h30});
    rd(4'h2, 8'h02);
    wr(4'h4, 8'h01);
    rd(4'h4, 8'h00);
    chk(irq, 1'b0);
    wait_rdy;
    rd(4'h4, 8'h01);
    chk(irq, 1'b1);
    wr(4'h3, 8'h00);
    @(posedge clk);
    #1 chk(irq, 1'b0);
    $display("eeprom erase done");
    @(posedge clk) slow <= 1'b0;
    from_prog_port <= 1'b1;
    wr(4'h0, 8'h00);
    wr(4'h0, 8'h20);
    chk({op_start, op_skip_eeprom}, 2'h3);
    rd(4'h2, 8'h01);
    wait_rdy;
    // Fuse clear: chip erase takes the EEPROM along
    @(posedge clk) fuse <= 1'b0;
    wr(4'h0, 8'h00);
    wr(4'h0, 8'h20);
    chk({op_start, op_skip_eeprom}, 2'h2);
    rd(4'h2, 8'h03);
    wait_rdy;
    @(posedge clk) from_prog_port <= 1'b0;
    $display("chip erase done");
    @(posedge clk) reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    foreach (rst_tab[j]) rd(rst_tab[j][11:8], rst_tab[j][7:0]);
    chk(flash_window, 2'h3);
    // Frozen clock enable: the enable write must be lost
    @(posedge clk) clk_en <= 1'b0;
    wr(4'h3, 8'h01);
    @(posedge clk) clk_en <= 1'b1;
    rd(4'h3, 8'h00);
    $display("reset test done");
    wr(4'h1, 8'h32);
    rd(4'h1, 8'h30);
    @(posedge clk) pc_in_boot <= 1'b1;
    wr(4'h1, 8'h32);
    // Still inside boot: protection not yet in force
    mrd(1'b1, 1'b1, 16'h1234);
    @(posedge clk) pc_in_boot <= 1'b0;
    rd(4'h1, 8'h32);
    mrd(1'b1, 1'b0, 16'h0000);
    mrd(1'b1, 1'b1, NOP_W);
    mrd(1'b0, 1'b0, 16'h1234);
    $display("boot protect done");
    stop_test;
  end
endmodule
